// ==== tsop_pkg.sv ====
// constants and types shared by the time-slotted sample output port
package tsop_pkg;

   // register byte offsets on the avalon slave
   localparam logic [3:0]  ADDR_CTRL      = 4'h0;
   localparam logic [3:0]  ADDR_STATUS    = 4'h4;
   localparam logic [3:0]  ADDR_RESULT    = 4'h8;

   // control register fields and reset value
   localparam int          CTRL_EN_BIT    = 0;
   localparam int          CTRL_LP_BIT    = 1;
   localparam logic [1:0]  CTRL_RESET     = 2'h1;

   // status register fields
   localparam int          ST_SLOT_LSB    = 0;
   localparam int          ST_LP_BIT      = 3;
   localparam int          ST_TEST_BIT    = 4;
   localparam int          ST_OVR_BIT     = 5;
   localparam int          ST_VALID_BIT   = 6;

   // positions of the pin inputs in the synchroniser vector
   localparam int          PIN_W          = 8;
   localparam int          IN_MCLK        = 0;
   localparam int          IN_FS          = 1;
   localparam int          IN_LP          = 2;
   localparam int          IN_TS0         = 3;
   localparam int          IN_TS1         = 4;
   localparam int          IN_TS2         = 5;
   localparam int          IN_TEST        = 6;
   localparam int          IN_MOD         = 7;

   // word timing in master clock edges: 32 per word, 4 per slot
   localparam logic [4:0]  TICK_LAST      = 5'h1f;
   localparam int          BYTE_SEL_BIT   = 1;
   localparam int          SLOT_LSB       = 2;

   // result word layout and accumulator step per modulator one
   localparam int          WORD_W         = 16;
   localparam logic [11:0] ACC_STEP       = 12'h080;
   localparam logic [11:0] ACC_FULL       = 12'hfff;

   // output drive state, one-hot
   typedef enum logic [2:0] {
      TSOP_IDLE = 3'b001,
      TSOP_HIGH = 3'b010,
      TSOP_LOW  = 3'b100
   } tsop_bus_st_t;

endpackage

// ==== tsop_buf2.sv ====
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module tsop_buf2 (
   // clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        srst,
   // filling side
   input  wire logic                        in_valid,
   output logic                             in_ready,
   input  wire logic [tsop_pkg::WORD_W-1:0] in_data,
   // draining side
   output logic                             out_valid,
   input  wire logic                        out_ready,
   output logic [tsop_pkg::WORD_W-1:0]      out_data
);

   typedef struct packed {
      logic [1:0][tsop_pkg::WORD_W-1:0] mem;
      logic                             rd;
      logic [1:0]                       cnt;
   } tsop_buf_st_t;

   tsop_buf_st_t q;
   tsop_buf_st_t n;
   logic         wr_en;
   logic         rd_en;

   // full and empty straight from the entry count
   assign in_ready  = (q.cnt != 2'h2);
   assign out_valid = (q.cnt != 2'h0);
   assign out_data  = q.mem[q.rd];

   // next state: write behind the read pointer, pop from it
   always_comb begin
      n     = q;
      wr_en = in_valid & in_ready;
      rd_en = out_ready & out_valid;
      if (wr_en) begin
         n.mem[q.rd ^ q.cnt[0]] = in_data;
      end
      if (rd_en) begin
         n.rd = ~q.rd;
      end
      n.cnt = q.cnt + {1'b0, wr_en} - {1'b0, rd_en};
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

endmodule

// ==== tsop_port.sv ====
// time-slotted byte output port of the converter with avalon register slave
// Operation
// [R1] three slot inputs pick one of eight periods
// [R2] frame rising edge restarts the decimation filter
// [R3] frame rising edge zeroes the slot counter
// [R4] bus driven only in own slot
// [R5] two bytes, high eight data bits first
// [R6] second byte: four data, three status, spare
// [R7] low power request high stops the port
// [R8] partner supplies steady master clock, nominally 1.024 MHz
// [R9] partner ties test input to ground
// [R10] one word every 32 master clocks
// [R11] each converter on a bus gets own slot
// [R12] slot index binary, bit2 most significant
// [R13] reader captures both bytes inside the slot
`timescale 1ns/1ps
module tsop_port (
   // system clock and reset
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // converter pins
   input  wire logic        master_clock_in,
   input  wire logic        frame_restart_in,
   input  wire logic        low_power_request,
   input  wire logic        slot_select_bit0,
   input  wire logic        slot_select_bit1,
   input  wire logic        slot_select_bit2,
   input  wire logic        factory_test_in,
   input  wire logic        modulator_bit_in,
   // shared byte bus
   output logic [7:0]       result_byte_bus_out,
   output logic             result_byte_bus_oe,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest
);

   typedef struct packed {
      logic [tsop_pkg::PIN_W-1:0]  s1;
      logic [tsop_pkg::PIN_W-1:0]  s2;
      logic [tsop_pkg::PIN_W-1:0]  s3;
      logic [tsop_pkg::PIN_W-1:0]  stab;
      logic [4:0]                  tick;
      logic [11:0]                 acc;
      logic                        sat;
      logic [tsop_pkg::WORD_W-1:0] cur_word;
      logic                        cur_valid;
      tsop_pkg::tsop_bus_st_t      bst;
      logic [7:0]                  bus_out;
      logic                        bus_oe;
      logic [1:0]                  ctrl;
      logic                        overrun;
      logic [tsop_pkg::WORD_W-1:0] last_word;
      logic                        waitreq;
      logic [31:0]                 rdata;
   } tsop_st_t;

   tsop_st_t                    q;
   tsop_st_t                    n;
   logic                        mclk_rise;
   logic                        fs_rise;
   logic                        lp_act;
   logic [2:0]                  slot_sel;
   logic [12:0]                 acc_sum;
   logic [11:0]                 acc_next;
   logic                        sat_next;
   logic                        buf_push;
   logic                        buf_in_ready;
   logic [tsop_pkg::WORD_W-1:0] buf_word;
   logic                        buf_pop;
   logic                        buf_out_valid;
   logic [tsop_pkg::WORD_W-1:0] buf_out_word;

   // words wait here until the output sequencer takes them
   tsop_buf2 tsop_buf2_i (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .in_valid  (buf_push),
      .in_ready  (buf_in_ready),
      .in_data   (buf_word),
      .out_valid (buf_out_valid),
      .out_ready (buf_pop),
      .out_data  (buf_out_word)
   );

   // outputs straight from the state register
   assign result_byte_bus_out = q.bus_out;
   assign result_byte_bus_oe  = q.bus_oe;
   assign avs_readdata        = q.rdata;
   assign avs_waitrequest     = q.waitreq;

   // next state of the whole port
   always_comb begin
      n         = q;
      buf_push  = 1'b0;
      buf_pop   = 1'b0;
      buf_word  = '0;
      acc_sum   = '0;
      acc_next  = q.acc;
      sat_next  = q.sat;
      // three-stage synchronisers; a change counts when stages two and three agree
      n.s1      = {modulator_bit_in, factory_test_in, slot_select_bit2, slot_select_bit1,
                   slot_select_bit0, low_power_request, frame_restart_in, master_clock_in};
      n.s2      = q.s1;
      n.s3      = q.s2;
      n.stab    = (q.s2 & q.s3) | (q.stab & (q.s2 | q.s3));
      mclk_rise = n.stab[tsop_pkg::IN_MCLK] & ~q.stab[tsop_pkg::IN_MCLK];   // [R8]
      fs_rise   = n.stab[tsop_pkg::IN_FS] & ~q.stab[tsop_pkg::IN_FS];
      lp_act    = n.stab[tsop_pkg::IN_LP] | q.ctrl[tsop_pkg::CTRL_LP_BIT];
      slot_sel  = {n.stab[tsop_pkg::IN_TS2], n.stab[tsop_pkg::IN_TS1],
                   n.stab[tsop_pkg::IN_TS0]};                               // [R12]

      // conversion: low power parks it, frame edge restarts it, else step per master edge
      if (lp_act) begin                                                    // [R7]
         n.tick      = '0;
         n.acc       = '0;
         n.sat       = 1'b0;
         n.cur_valid = 1'b0;
      end else if (fs_rise) begin
         n.acc       = '0;                                                 // [R2]
         n.sat       = 1'b0;
         n.cur_valid = 1'b0;
         n.tick      = '0;                                                 // [R3]
      end else if (mclk_rise) begin
         acc_sum  = {1'b0, q.acc} + {1'b0, (n.stab[tsop_pkg::IN_MOD] ? tsop_pkg::ACC_STEP : 12'h000)};
         acc_next = acc_sum[12] ? tsop_pkg::ACC_FULL : acc_sum[11:0];
         sat_next = q.sat | acc_sum[12];
         n.tick   = q.tick + 5'h01;
         n.acc    = acc_next;
         n.sat    = sat_next;
         if (q.tick == tsop_pkg::TICK_LAST) begin                          // [R10]
            // low byte: four data bits, three status bits, one spare
            buf_word    = {acc_next, q.overrun, n.stab[tsop_pkg::IN_TEST], sat_next, 1'b0};  // [R6]
            buf_push    = 1'b1;
            n.last_word = buf_word;
            n.acc       = '0;
            n.sat       = 1'b0;
            buf_pop     = q.ctrl[tsop_pkg::CTRL_EN_BIT] & buf_out_valid;
            n.cur_valid = buf_pop;
            if (buf_pop) begin
               n.cur_word = buf_out_word;
            end
         end
      end

      // a word the buffer cannot take is lost and flagged; the set beats a clear
      if (avs_write && !q.waitreq && avs_address == tsop_pkg::ADDR_STATUS &&
          avs_writedata[tsop_pkg::ST_OVR_BIT]) begin
         n.overrun = 1'b0;
      end
      if (buf_push && !buf_in_ready) begin
         n.overrun = 1'b1;
      end

      // bus drive: only inside the selected slot, high byte in the slot's first half
      if (n.cur_valid && !lp_act && n.tick[4:tsop_pkg::SLOT_LSB] == slot_sel) begin  // [R1] [R4]
         n.bst = n.tick[tsop_pkg::BYTE_SEL_BIT] ? tsop_pkg::TSOP_LOW : tsop_pkg::TSOP_HIGH;
      end else begin
         n.bst = tsop_pkg::TSOP_IDLE;
      end
      case (n.bst)
         tsop_pkg::TSOP_HIGH: begin
            n.bus_out = n.cur_word[15:8];                                  // [R5]
            n.bus_oe  = 1'b1;
         end
         tsop_pkg::TSOP_LOW: begin
            n.bus_out = n.cur_word[7:0];                                   // [R6]
            n.bus_oe  = 1'b1;
         end
         default: begin
            n.bus_out = 8'h00;
            n.bus_oe  = 1'b0;                                              // [R4]
         end
      endcase

      // avalon slave: waitrequest drops for one cycle, read data loaded with it
      n.waitreq = 1'b1;
      if ((avs_read || avs_write) && q.waitreq) begin
         n.waitreq = 1'b0;
         n.rdata   = 32'h0000_0000;
         case (avs_address)
            tsop_pkg::ADDR_CTRL: begin
               n.rdata[1:0] = q.ctrl;
            end
            tsop_pkg::ADDR_STATUS: begin
               n.rdata[tsop_pkg::ST_SLOT_LSB+:3]  = slot_sel;
               n.rdata[tsop_pkg::ST_LP_BIT]       = lp_act;
               n.rdata[tsop_pkg::ST_TEST_BIT]     = n.stab[tsop_pkg::IN_TEST];    // [R9]
               n.rdata[tsop_pkg::ST_OVR_BIT]      = q.overrun;
               n.rdata[tsop_pkg::ST_VALID_BIT]    = q.cur_valid;
            end
            tsop_pkg::ADDR_RESULT: begin
               n.rdata[tsop_pkg::WORD_W-1:0] = q.last_word;
            end
            default: begin
               n.rdata = 32'h0000_0000;
            end
         endcase
      end
      if (avs_write && !q.waitreq && avs_address == tsop_pkg::ADDR_CTRL) begin
         n.ctrl = avs_writedata[1:0];
      end
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         q         <= '0;
         q.bst     <= tsop_pkg::TSOP_IDLE;
         q.ctrl    <= tsop_pkg::CTRL_RESET;
         q.waitreq <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // checks on the port behaviour
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence seq_bus_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   sequence seq_bus_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   AST_DRIVE_IN_SLOT: assert property (result_byte_bus_oe |-> q.tick[4:2] == $past(slot_sel)) // [R1] [R12]
      else $error("bus driven outside the selected slot");
   AST_FRAME_RESTART: assert property (fs_rise && !lp_act |=> q.acc == 12'h000 && !q.sat) // [R2]
      else $error("frame edge did not restart the filter");
   AST_FRAME_SLOT_ZERO: assert property (fs_rise && !lp_act |=> q.tick == 5'h00 && !result_byte_bus_oe) // [R3]
      else $error("frame edge did not zero the slot counter");
   AST_QUIET_OUTSIDE: assert property (!q.cur_valid |-> !result_byte_bus_oe) // [R4]
      else $error("bus driven without a word to send");
   AST_HIGH_FIRST: assert property (result_byte_bus_oe && !q.tick[1] |->
                                    result_byte_bus_out == q.cur_word[15:8]) // [R5]
      else $error("first byte is not the high data byte");
   AST_LOW_SECOND: assert property (result_byte_bus_oe && q.tick[1] |-> result_byte_bus_out == q.cur_word[7:0]
                                    && !result_byte_bus_out[0]) // [R6]
      else $error("second byte wrong or spare bit set");
   AST_LOW_POWER: assert property (lp_act |=> !result_byte_bus_oe && q.tick == 5'h00) // [R7]
      else $error("port active during low power");
   AST_WORD_RATE: assert property (buf_push |-> mclk_rise && q.tick == 5'h1f ##1 q.tick == 5'h00) // [R10]
      else $error("word not produced on the 32nd master edge");
   AST_BUS_ANSWER: assert property (seq_bus_req |=> seq_bus_ack)
      else $error("avalon request not answered in one cycle");

endmodule

// ==== tsop_dsp_model.sv ====
// far-side reader model: master clock, frame sync, modulator feed and byte capture
`timescale 1ns/1ps
module tsop_dsp_model (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // requests from the bench
   input  wire logic        fs_req,
   input  wire logic        mod_lvl,
   input  wire logic [2:0]  slot,
   // shared byte bus
   input  wire logic [7:0]  bus_in,
   input  wire logic        bus_oe,
   // pins driven into the converter
   output logic             mclk,
   output logic             fs,
   output logic             mod_bit,
   output logic             test_pin,
   // capture results
   output logic [4:0]       tick_idx,
   output logic [15:0]      word_q,
   output int               word_cnt,
   output logic             stray
);
   logic [2:0] div;
   logic [1:0] nb;
   logic [7:0] hi;

   // master clock scaled to 16 system cycles, capture on its falling edge
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         div      <= 3'h0;
         mclk     <= 1'b0;
         fs       <= 1'b0;
         tick_idx <= 5'h00;
         nb       <= 2'h0;
         hi       <= 8'h00;
         word_q   <= 16'h0000;
         word_cnt <= 0;
         stray    <= 1'b0;
      end else begin
         div <= div + 3'h1;
         if (div == 3'h7) begin
            mclk <= ~mclk;
            if (!mclk) begin
               tick_idx <= tick_idx + 5'h01;
            end else begin
               fs <= fs_req;
               if (fs_req && !fs) begin
                  tick_idx <= 5'h00;
               end
               if (bus_oe && !fs_req) begin
                  nb <= nb + 2'h1;
                  if (nb == 2'h0) begin
                     hi <= bus_in;
                  end
                  if (nb == 2'h2) begin
                     word_q   <= {hi, bus_in};
                     word_cnt <= word_cnt + 1;
                  end
                  if (tick_idx[4:2] != slot) begin
                     stray <= 1'b1;
                  end
               end else begin
                  nb <= 2'h0;
               end
            end
         end
      end
   end

   // modulator follows the bench, test pin held at ground
   always_ff @(posedge clk_sys) begin
      mod_bit  <= mod_lvl;
      test_pin <= 1'b0;
   end
endmodule

// ==== tsop_port_tb.sv ====
// self-checking bench of the slotted output port with its reader model
`timescale 1ns/1ps
module tsop_port_tb;
   localparam int PER = 512; // system cycles per word period
   logic        clk_sys, srst, lp_pin, fs_req, mod_lvl, stray;
   logic        avs_read, avs_write, avs_waitrequest, bus_oe, mclk, fs, mod_bit, test_pin;
   logic [2:0]  slot;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [7:0]  bus_out;
   logic [4:0]  tick_idx;
   logic [15:0] word_q, exp_w;
   int          word_cnt, error_cnt, cmp_count, n0;

   // system clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   tsop_port tsop_port_i (.clk_sys(clk_sys), .srst(srst), .master_clock_in(mclk), .frame_restart_in(fs),
      .low_power_request(lp_pin), .slot_select_bit0(slot[0]), .slot_select_bit1(slot[1]),
      .slot_select_bit2(slot[2]), .factory_test_in(test_pin), .modulator_bit_in(mod_bit),
      .result_byte_bus_out(bus_out), .result_byte_bus_oe(bus_oe), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   tsop_dsp_model tsop_dsp_model_i (.clk_sys(clk_sys), .srst(srst), .fs_req(fs_req), .mod_lvl(mod_lvl),
      .slot(slot), .bus_in(bus_out), .bus_oe(bus_oe), .mclk(mclk), .fs(fs), .mod_bit(mod_bit),
      .test_pin(test_pin), .tick_idx(tick_idx), .word_q(word_q), .word_cnt(word_cnt), .stray(stray));

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // one avalon access, held until waitrequest is seen low
   task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= wd;
      // only the watchdog ends a wait that never sees waitrequest low
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wait_per(input int k);
      repeat (k * PER) @(posedge clk_sys);
   endtask

   // frame pulse through the reader model; slot and modulator change with the request
   task automatic frame(input logic [2:0] sl, input logic m);
      @(posedge clk_sys);
      slot    <= sl;
      mod_lvl <= m;
      fs_req  <= 1'b1;
      repeat (20) @(posedge clk_sys);
      fs_req <= 1'b0;
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // watchdog against a hung run
   initial begin
      repeat (60000) @(posedge clk_sys);
      error_cnt++;
      $display("ERROR at %0t: watchdog expired", $time);
      conclude();
   end

   // main sequence
   initial begin
      srst = 1'b1; lp_pin = 1'b0; fs_req = 1'b0; mod_lvl = 1'b0; slot = 3'h0;
      avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0000_0000;
      error_cnt = 0; cmp_count = 0;
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      acc(1'b0, tsop_pkg::ADDR_CTRL, 32'h0000_0000);
      chk(rd, {30'h0, tsop_pkg::CTRL_RESET}, "ctrl reset value");
      acc(1'b1, 4'hc, 32'hffff_ffff);
      acc(1'b0, 4'hc, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "unmapped read");
      $display("test registers done");
      // every slot, alternating all-zero and all-one modulator streams
      for (int s = 0; s < 8; s++) begin
         exp_w    = s[0] ? 16'hfff2 : 16'h0000;
         frame(3'(s), s[0]);
         wait_per(4);
         chk({16'h0, word_q}, {16'h0, exp_w}, "captured word");
         chk({31'h0, stray}, 32'h0, "byte outside slot");
         acc(1'b0, tsop_pkg::ADDR_STATUS, 32'h0000_0000);
         chk({29'h0, rd[2:0]}, 32'(s), "status slot");
         chk({31'h0, rd[tsop_pkg::ST_TEST_BIT]}, 32'h0, "test pin status");
         acc(1'b0, tsop_pkg::ADDR_RESULT, 32'h0000_0000);
         chk({16'h0, rd[15:0]}, {16'h0, exp_w}, "result register");
      end
      $display("test slot sweep done");
      n0 = word_cnt;
      wait_per(8);
      chk(word_cnt - n0, 32'h0000_0008, "words per eight periods");
      $display("test word rate done");
      // disable popping so the buffer overflows, then clear the sticky flag
      acc(1'b1, tsop_pkg::ADDR_CTRL, 32'h0000_0000);
      wait_per(4);
      acc(1'b0, tsop_pkg::ADDR_STATUS, 32'h0000_0000);
      chk({31'h0, rd[tsop_pkg::ST_OVR_BIT]}, 32'h1, "overrun set");
      // popping again brings the full buffer down to one word within two periods, so the clear then sticks
      acc(1'b1, tsop_pkg::ADDR_CTRL, {30'h0, tsop_pkg::CTRL_RESET});
      wait_per(2);
      acc(1'b1, tsop_pkg::ADDR_STATUS, 32'h0000_0020);
      acc(1'b0, tsop_pkg::ADDR_STATUS, 32'h0000_0000);
      chk({31'h0, rd[tsop_pkg::ST_OVR_BIT]}, 32'h0, "overrun cleared");
      $display("test overrun done");
      // low power by pin, then by control bit
      for (int m = 0; m < 2; m++) begin
         if (m == 0) begin
            lp_pin <= 1'b1;
         end else begin
            acc(1'b1, tsop_pkg::ADDR_CTRL, 32'h0000_0003);
         end
         wait_per(2);
         n0 = word_cnt;
         wait_per(4);
         chk(word_cnt - n0, 32'h0, "words in low power");
         acc(1'b0, tsop_pkg::ADDR_STATUS, 32'h0000_0000);
         chk({31'h0, rd[tsop_pkg::ST_LP_BIT]}, 32'h1, "low power status");
         lp_pin <= 1'b0;
         acc(1'b1, tsop_pkg::ADDR_CTRL, {30'h0, tsop_pkg::CTRL_RESET});
         wait_per(4);
         chk({31'h0, word_cnt > n0}, 32'h1, "words after wake");
      end
      $display("test low power done");
      conclude();
   end
endmodule
